// ===== wdtrf_pkg.sv
package wdtrf_pkg;

  // register offsets, data space and short i/o space
  localparam logic [7:0] CAUSE_DS_OFS  = 8'h54;
  localparam logic [7:0] IO_SPACE_BIAS = 8'h20;
  localparam logic [7:0] CAUSE_IO_OFS  = CAUSE_DS_OFS - IO_SPACE_BIAS;
  localparam logic [7:0] CTRL_DS_OFS   = 8'h60;

  // field positions of the cause register
  localparam int WDOG_FLAG_BIT     = 3;
  localparam int BROWNOUT_FLAG_BIT = 2;
  localparam int PIN_FLAG_BIT      = 1;
  localparam int POWERON_FLAG_BIT  = 0;

  // values after reset; power-on loads the cause register with 4'b0001, not CAUSE_RESET
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // timing
  localparam int            OSC_FREQ_KHZ  = 128;
  localparam int            UNLOCK_CYCLES = 4;
  localparam logic [1:0]    UNLOCK_LOAD   = 2'(UNLOCK_CYCLES - 1);
  localparam int            CNT_W         = 21;
  localparam logic [20:0]   TIMEOUT_BASE  = 21'h000800;
  localparam logic [3:0]    SEL_MAX_CODE  = 4'h9;

  // control register, laid out bit for bit
  typedef struct packed {
    logic       irq_flag;
    logic       irq_enable;
    logic       sel_hi;
    logic       change_unlock;
    logic       reset_enable;
    logic [2:0] sel_lo;
  } wdtrf_ctrl_t;

  // reset cause flags, low nibble of the cause register
  typedef struct packed {
    logic wdog;
    logic brownout;
    logic pin;
    logic poweron;
  } wdtrf_cause_t;

  // one register access from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdtrf_bus_t;

  typedef enum logic [3:0] {
    MODE_STOPPED  = 4'b0001,
    MODE_IRQ      = 4'b0010,
    MODE_RESET    = 4'b0100,
    MODE_COMBINED = 4'b1000
  } wdtrf_mode_t;

endpackage

// ===== wdtrf_top.sv
`timescale 1ns/10ps
module wdtrf_top
  import wdtrf_pkg::*;
(
  // clock and power-on reset
  input  wire logic       MCLK_IN,
  input  wire logic       RST_IN,
  // register access from the core
  input  wire logic       RD_IN,
  input  wire logic       WR_IN,
  input  wire logic       IO_SPACE_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  output logic      [7:0] RDATA_OUT,
  // core events
  input  wire logic       RESTART_IN,
  input  wire logic       IRQ_ACK_IN,
  input  wire logic       GLOBAL_IRQ_EN_IN,
  output logic            IRQ_OUT,
  // oscillator tick, fuse, other reset sources
  input  wire logic       OSC_TICK_IN,
  input  wire logic       FORCE_RESET_FUSE_IN,
  input  wire logic       BROWNOUT_RST_IN,
  input  wire logic       PIN_RST_IN,
  output logic            WDOG_RST_OUT
);

  wdtrf_bus_t         bus;
  wdtrf_ctrl_t        ctrl;
  wdtrf_ctrl_t        next_ctrl;
  wdtrf_ctrl_t        wr_ctrl_val;
  wdtrf_cause_t       cause;
  wdtrf_cause_t       next_cause;
  wdtrf_mode_t        mode;
  logic [1:0]         unlock_cnt;
  logic [1:0]         next_unlock_cnt;
  logic [CNT_W-1:0]   count;
  logic [CNT_W-1:0]   next_count;
  logic [CNT_W-1:0]   limit;
  logic [3:0]         sel_code;
  logic [7:0]         rdata;
  logic [7:0]         next_rdata;
  logic               next_wdog_rst;
  logic               fuse_programmed;
  logic               eff_irq_enable;
  logic               eff_reset_enable;
  logic               wr_cause;
  logic               wr_ctrl;
  logic               rd_cause;
  logic               rd_ctrl;
  logic               expire;
  logic               timeout_irq;
  logic               timeout_rst;
  logic               sys_reset;
  logic               unlock_req;

  assign bus = '{rd: RD_IN, wr: WR_IN, io_space: IO_SPACE_IN,
                 addr: ADDR_IN, wdata: WDATA_IN};
  assign wr_ctrl_val = wdtrf_ctrl_t'(bus.wdata);

  // address decode; the control register lies above the short i/o range
  // unmapped addresses read as zero and swallow writes
  always_comb begin
    wr_cause = 1'b0;
    wr_ctrl  = 1'b0;
    rd_cause = 1'b0;
    rd_ctrl  = 1'b0;
    if (bus.io_space && bus.addr == CAUSE_IO_OFS) begin
      wr_cause = bus.wr;
      rd_cause = bus.rd;
    end else if (!bus.io_space && bus.addr == CAUSE_DS_OFS) begin
      wr_cause = bus.wr;
      rd_cause = bus.rd;
    end else if (!bus.io_space && bus.addr == CTRL_DS_OFS) begin
      wr_ctrl = bus.wr;
      rd_ctrl = bus.rd;
    end
  end

  // mode selection; the fuse pins enables to reset-only
  assign fuse_programmed  = ~FORCE_RESET_FUSE_IN;
  assign eff_irq_enable   = ctrl.irq_enable & ~fuse_programmed;
  assign eff_reset_enable = ctrl.reset_enable | fuse_programmed;

  always_comb begin
    case ({eff_reset_enable, eff_irq_enable})
      2'b01:   mode = MODE_IRQ;
      2'b10:   mode = MODE_RESET;
      2'b11:   mode = MODE_COMBINED;
      default: mode = MODE_STOPPED;
    endcase
  end

  // time-out length; reserved codes fall back to the longest period
  // nothing refuses a reserved code, but only an unlocked write sets one
  assign sel_code = {ctrl.sel_hi, ctrl.sel_lo};
  always_comb begin
    if (sel_code > SEL_MAX_CODE) begin
      limit = TIMEOUT_BASE << SEL_MAX_CODE;
    end else begin
      limit = TIMEOUT_BASE << sel_code;
    end
  end

  // a restart on the last tick wins, so a core that kicks just in time
  // is never reset for the race
  assign expire = OSC_TICK_IN && mode != MODE_STOPPED && !RESTART_IN
                  && count == limit - 21'h000001;

  always_comb begin
    timeout_irq = 1'b0;
    timeout_rst = 1'b0;
    case (mode)
      MODE_IRQ: begin
        timeout_irq = expire;
      end
      MODE_RESET: begin
        timeout_rst = expire;
      end
      MODE_COMBINED: begin
        // a flag still pending at the next time-out means the handler died
        timeout_irq = expire & ~ctrl.irq_flag;
        timeout_rst = expire & ctrl.irq_flag;
      end
      default: begin
        timeout_irq = 1'b0;
        timeout_rst = 1'b0;
      end
    endcase
  end

  // any system reset restores the control register's reset state, but the watchdog flag holds reset enable set and a same-cycle time-out sets the irq flag
  assign sys_reset = timeout_rst | BROWNOUT_RST_IN | PIN_RST_IN;
  assign unlock_req = wr_ctrl & wr_ctrl_val.change_unlock
                      & wr_ctrl_val.reset_enable;

  // counter; stopped mode parks it at zero, so enabling the watchdog
  // always starts a full period
  always_comb begin
    next_count = count + 21'h000001;
    if (RESTART_IN || sys_reset || mode == MODE_STOPPED) begin
      next_count = '0;
    end else if (expire) begin
      next_count = '0;
    end else if (!OSC_TICK_IN) begin
      next_count = count;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // control register and unlock window
  always_comb begin
    next_ctrl       = ctrl;
    next_unlock_cnt = unlock_cnt;
    // the window counts down on every clock; a control write closes it or reloads it
    if (ctrl.change_unlock) begin
      if (unlock_cnt == 2'h0) begin
        next_ctrl.change_unlock = 1'b0;
      end else begin
        next_unlock_cnt = unlock_cnt - 2'h1;
      end
    end
    if (wr_ctrl) begin
      next_ctrl.irq_enable = wr_ctrl_val.irq_enable;
      if (wr_ctrl_val.irq_flag) begin
        next_ctrl.irq_flag = 1'b0;
      end
      if (wr_ctrl_val.reset_enable) begin
        next_ctrl.reset_enable = 1'b1;
      end else if (ctrl.change_unlock) begin
        next_ctrl.reset_enable = 1'b0;
      end
      if (ctrl.change_unlock) begin
        next_ctrl.sel_hi = wr_ctrl_val.sel_hi;
        next_ctrl.sel_lo = wr_ctrl_val.sel_lo;
      end
      // any other control write uses up the window at once
      if (unlock_req) begin
        next_ctrl.change_unlock = 1'b1;
        next_unlock_cnt         = UNLOCK_LOAD;
      end else begin
        next_ctrl.change_unlock = 1'b0;
      end
    end
    // in combined mode the vector drops back to pure reset mode
    if (IRQ_ACK_IN) begin
      next_ctrl.irq_flag = 1'b0;
      if (mode == MODE_COMBINED) begin
        next_ctrl.irq_enable = 1'b0;
      end
    end
    if (sys_reset) begin
      next_ctrl       = wdtrf_ctrl_t'(CTRL_RESET);
      next_unlock_cnt = 2'h0;
    end
    // set wins over any clear in the same cycle
    if (timeout_irq) begin
      next_ctrl.irq_flag = 1'b1;
    end
    // the flag pins reset enable up, so code that runs away after a
    // watchdog reset cannot switch the watchdog off again
    if (next_cause.wdog) begin
      next_ctrl.reset_enable = 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl       <= wdtrf_ctrl_t'(CTRL_RESET);
      unlock_cnt <= 2'h0;
    end else begin
      ctrl       <= next_ctrl;
      unlock_cnt <= next_unlock_cnt;
    end
  end

  // reset cause flags; software can only clear them
  // bits written 1 keep their value, so read-modify-write is harmless
  always_comb begin
    next_cause = cause;
    if (wr_cause) begin
      next_cause = cause & wdtrf_cause_t'(bus.wdata[3:0]);
    end
    if (timeout_rst) begin
      next_cause.wdog = 1'b1;
    end
    if (BROWNOUT_RST_IN) begin
      next_cause.brownout = 1'b1;
    end
    if (PIN_RST_IN) begin
      next_cause.pin = 1'b1;
    end
  end

  // power-on clears the others and leaves only its own flag standing
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cause <= 4'b0001;
    end else begin
      cause <= next_cause;
    end
  end

  // read data and reset pulse
  // reads show the effective enables, so software sees what the fuse forces
  always_comb begin
    next_rdata = 8'h00;
    if (rd_cause) begin
      next_rdata = {4'h0, cause};
    end else if (rd_ctrl) begin
      next_rdata = {ctrl.irq_flag, eff_irq_enable, ctrl.sel_hi,
                    ctrl.change_unlock, eff_reset_enable, ctrl.sel_lo};
    end
    next_wdog_rst = timeout_rst;
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata        <= 8'h00;
      WDOG_RST_OUT <= 1'b0;
    end else begin
      rdata        <= next_rdata;
      WDOG_RST_OUT <= next_wdog_rst;
    end
  end

  assign RDATA_OUT = rdata;
  // level request to the core; it drops as soon as the flag clears
  assign IRQ_OUT   = GLOBAL_IRQ_EN_IN & eff_irq_enable & ctrl.irq_flag;

endmodule

// ===== wdtrf_top_properties.sv
`timescale 1ns/10ps
module wdtrf_chk
  import wdtrf_pkg::*;
(
  // every port of the watchdog that a property needs
  input wire logic       MCLK_IN,
  input wire logic       RST_IN,
  input wire logic       RD_IN,
  input wire logic       WR_IN,
  input wire logic       IO_SPACE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       RESTART_IN,
  input wire logic       IRQ_ACK_IN,
  input wire logic       GLOBAL_IRQ_EN_IN,
  input wire logic       IRQ_OUT,
  input wire logic       OSC_TICK_IN,
  input wire logic       FORCE_RESET_FUSE_IN,
  input wire logic       WDOG_RST_OUT
);
  logic rdc;
  logic rdk;
  logic uw;
  assign rdc = RD_IN & (IO_SPACE_IN ? ADDR_IN == CAUSE_IO_OFS
                                    : ADDR_IN == CAUSE_DS_OFS);
  assign rdk = RD_IN & !IO_SPACE_IN & (ADDR_IN == CTRL_DS_OFS);
  assign uw  = WR_IN & !IO_SPACE_IN & (ADDR_IN == CTRL_DS_OFS)
             & (&WDATA_IN[4:3]);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  a_rst_one_cycle: assert property (
    WDOG_RST_OUT |=> !WDOG_RST_OUT)
    else $error("watchdog reset wider than one cycle");
  a_rdata_idle: assert property (
    !RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data without a read");
  a_cause_upper: assert property (
    rdc |=> RDATA_OUT[7:4] == 4'h0)
    else $error("cause register upper bits not zero");
  a_irq_gated: assert property (
    IRQ_OUT |-> GLOBAL_IRQ_EN_IN)
    else $error("interrupt without global enable");
  a_fuse_no_irq: assert property (
    !FORCE_RESET_FUSE_IN |-> !IRQ_OUT)
    else $error("interrupt while fuse forces reset mode");
  a_fuse_view: assert property (
    !FORCE_RESET_FUSE_IN && rdk |=> !RDATA_OUT[6] && RDATA_OUT[3])
    else $error("fuse does not lock the enables");
  a_ack_clears: assert property (
    IRQ_ACK_IN && IRQ_OUT && !OSC_TICK_IN |=> !IRQ_OUT)
    else $error("vector did not clear the interrupt");
  a_restart_quiet: assert property (
    RESTART_IN |=> !WDOG_RST_OUT [*8])
    else $error("reset right after a restart");
  a_unlock_open: assert property (
    uw ##1 !WR_IN [*3] ##1 (rdk && !WR_IN) |=> RDATA_OUT[4])
    else $error("unlock closed before four cycles");
  a_unlock_shut: assert property (
    uw ##1 !WR_IN [*4] ##1 rdk |=> !RDATA_OUT[4])
    else $error("unlock still open after four cycles");
  a_rst_no_irq: assert property (
    WDOG_RST_OUT |-> !IRQ_OUT)
    else $error("interrupt still raised during watchdog reset");
endmodule

bind wdtrf_top wdtrf_chk chk_u (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
  .RD_IN(RD_IN), .WR_IN(WR_IN), .IO_SPACE_IN(IO_SPACE_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT),
  .RESTART_IN(RESTART_IN), .IRQ_ACK_IN(IRQ_ACK_IN),
  .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN), .IRQ_OUT(IRQ_OUT),
  .OSC_TICK_IN(OSC_TICK_IN), .FORCE_RESET_FUSE_IN(FORCE_RESET_FUSE_IN),
  .WDOG_RST_OUT(WDOG_RST_OUT));

// ===== wdtrf_core.sv
`timescale 1ns/10ps
module wdtrf_core (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // interrupt handshake
  input  wire logic irq_in,
  input  wire logic ack_on_in,
  output logic      ack_out
);
  // the handler never re-arms the interrupt enable itself
  initial begin
    ack_out = 1'h0;
    forever begin
      @(posedge clk_in);
      if (irq_in && ack_on_in && !rst_in) begin
        repeat ($urandom_range(3)) @(posedge clk_in);
        // vector runs only while the request still stands
        #1 ack_out = irq_in;
        @(posedge clk_in);
        #1 ack_out = 1'h0;
      end
    end
  end
endmodule

// ===== wdtrf_top_bench.sv
`timescale 1ns/10ps
module wdtrf_top_bench;
  import wdtrf_pkg::*;
  logic       clk, rst, rd, wr, io, rs, ack, gen, tick, fuse, bo, pr;
  logic       irq, wrst, tick_on, ack_on;
  logic [7:0] addr, wd, rdata, v;
  int         errors, n_checks, n, k;

  wdtrf_top dut_u (.MCLK_IN(clk), .RST_IN(rst), .RD_IN(rd), .WR_IN(wr),
    .IO_SPACE_IN(io), .ADDR_IN(addr), .WDATA_IN(wd), .RDATA_OUT(rdata),
    .RESTART_IN(rs), .IRQ_ACK_IN(ack), .GLOBAL_IRQ_EN_IN(gen),
    .IRQ_OUT(irq), .OSC_TICK_IN(tick), .FORCE_RESET_FUSE_IN(fuse),
    .BROWNOUT_RST_IN(bo), .PIN_RST_IN(pr), .WDOG_RST_OUT(wrst));
  wdtrf_core core_u (.clk_in(clk), .rst_in(rst), .irq_in(irq),
    .ack_on_in(ack_on), .ack_out(ack));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // uneven tick spacing, so counts cannot lean on the system clock
  always @(posedge clk) tick <= #1 tick_on & ($urandom_range(1) == 1);

  function automatic int to_ticks(int s);
    return 32'h800 << ((s > 9) ? 9 : s);
  endfunction

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic acc(input logic w, input logic i,
                     input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {wr, rd, io, addr, wd} = {w, !w, i, a, d};
    @(posedge clk);
    #1 {wr, rd} = 2'h0;
    v = rdata;
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'h1;
    @(posedge clk);
    #1 s = 1'h0;
  endtask

  task automatic cfg(input logic [7:0] d);
    pulse(rs);
    acc(1, 0, CTRL_DS_OFS, 8'h18);
    acc(1, 0, CTRL_DS_OFS, d);
  endtask

  task automatic off;
    acc(1, 1, CAUSE_IO_OFS, 8'h00);
    cfg(8'h00);
  endtask

  // counts ticks until a reset pulse, or an interrupt when asked
  task automatic run(input logic want_irq);
    n = 0;
    tick_on = 1'h1;
    repeat (20000) begin
      @(posedge clk);
      if (wrst || (irq && want_irq))
        break;
      if (tick)
        n++;
    end
    #1 tick_on = 1'h0;
  endtask

  initial begin
    {rd, wr, io, rs, gen, bo, pr, tick, tick_on, ack_on} = '0;
    {addr, wd} = 16'h0000;
    fuse = 1'h1;
    rst = 1'h1;
    errors = 0;
    n_checks = 0;
    n = $urandom(32'h93c9);
    repeat (16) @(posedge clk);
    #1 rst = 1'h0;
    acc(0, 0, CAUSE_DS_OFS, 8'h00);
    chk("cause", 8'h01, v);
    acc(1, 0, CAUSE_DS_OFS, 8'h00);
    pulse(bo);
    pulse(pr);
    acc(0, 1, CAUSE_IO_OFS, 8'h00);
    chk("cause", 8'h06, v);
    pulse(rst);
    acc(0, 0, CAUSE_DS_OFS, 8'h00);
    chk("cause", 8'h01, v);
    acc(1, 0, CAUSE_DS_OFS, 8'h00);
    acc(1, 1, CTRL_DS_OFS, 8'h48);
    acc(1, 0, CTRL_DS_OFS, 8'h08);
    acc(1, 0, CTRL_DS_OFS, 8'h21);
    acc(0, 1, CTRL_DS_OFS, 8'h00);
    chk("unmapped", 8'h00, v);
    acc(0, 0, CTRL_DS_OFS, 8'h00);
    chk("ctrl", 8'h08, v);
    for (k = 2; k < 4; k++) begin
      acc(1, 0, CTRL_DS_OFS, 8'h18);
      repeat (k) @(posedge clk);
      acc(0, 0, CTRL_DS_OFS, 8'h00);
      chk("unlock", k == 2, v[4]);
    end
    for (k = 0; k < 2; k++) begin
      cfg(8'h08 | 8'(k));
      run(0);
      chk("ticks", to_ticks(k), n);
      acc(0, 0, CAUSE_DS_OFS, 8'h00);
      chk("cause", 8'h08, v);
      cfg(8'h00);
      acc(0, 0, CTRL_DS_OFS, 8'h00);
      chk("ctrl", 8'h08, v);
      off();
      acc(0, 0, CTRL_DS_OFS, 8'h00);
      chk("ctrl", 8'h00, v);
    end
    cfg(8'h29);
    acc(0, 0, CTRL_DS_OFS, 8'h00);
    chk("ctrl", 8'h29, v);
    off();
    gen = 1'h1;
    acc(1, 0, CTRL_DS_OFS, 8'h40);
    pulse(rs);
    run(1);
    chk("ticks", to_ticks(0), n);
    gen = 1'h0;
    #1 chk("irq", 1'h0, irq);
    @(posedge clk);
    #1 gen = 1'h1;
    #1 chk("irq", 1'h1, irq);
    acc(1, 0, CTRL_DS_OFS, 8'hc0);
    chk("irq", 1'h0, irq);
    ack_on = 1'h1;
    pulse(rs);
    run(1);
    repeat (8) @(posedge clk);
    acc(0, 0, CTRL_DS_OFS, 8'h00);
    chk("ctrl", 8'h40, v);
    acc(1, 0, CTRL_DS_OFS, 8'h48);
    pulse(rs);
    run(1);
    repeat (8) @(posedge clk);
    acc(0, 0, CTRL_DS_OFS, 8'h00);
    chk("ctrl", 8'h08, v);
    ack_on = 1'h0;
    acc(1, 0, CTRL_DS_OFS, 8'h48);
    pulse(rs);
    run(0);
    chk("ticks", 2 * to_ticks(0), n);
    acc(0, 0, CAUSE_DS_OFS, 8'h00);
    chk("cause", 8'h08, v);
    off();
    fuse = 1'h0;
    acc(1, 0, CTRL_DS_OFS, 8'h40);
    acc(0, 0, CTRL_DS_OFS, 8'h00);
    chk("ctrl", 8'h08, v);
    tick_on = 1'h1;
    repeat (1500) @(posedge clk);
    pulse(rs);
    run(0);
    chk("ticks", to_ticks(0), n);
    conclude();
  end

  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule
